// file: hw/mmd_addr_decode.sv
`timescale 1ns/10ps
`default_nettype none
`include "mmd_params.svh"

module mmd_addr_decode import mmd_pkg::*; #(
    parameter bit FULL_VARIANT = 1'b1
) (
    input wire logic [15:0] addr_i,
    input wire logic [5:0] ram_page_i,
    input wire logic [3:0] reg_page_i,
    input wire logic [3:0] nv_page_i,
    input wire logic nv_en_i,
    input wire logic fixed_nv_i,
    input wire logic boot_en_i,
    input wire logic ext_mode_i,
    output var mmd_tgt_t tgt_o
);
    // Masked compare of an address against a base
    function automatic logic hit(input logic [15:0] a, input logic [15:0] base,
                                 input logic [15:0] mask);
        return ((a ^ base) & mask) == 16'h0000;
    endfunction

    logic reg_hit;
    logic ram_hit;
    logic boot_hit;
    logic nv_hit;
    logic [15:0] nv_base;

    // ************************************
    // Region hits and priority
    // ************************************
    always_comb begin
        reg_hit = hit(addr_i, {reg_page_i, `MMD_REG_PAD}, `MMD_PAGE4K_MASK)
                  && (addr_i[11:0] < `MMD_REG_SPAN);
        ram_hit = hit(addr_i, {ram_page_i, `MMD_RAM_PAD}, `MMD_RAM_MASK);
        boot_hit = boot_en_i && hit(addr_i, `MMD_BOOT_BASE, `MMD_BOOT_MASK);
        nv_base = fixed_nv_i ? `MMD_NV_FIX_BASE : {nv_page_i, `MMD_NV_LOW};
        nv_hit = FULL_VARIANT && nv_en_i && hit(addr_i, nv_base, `MMD_NV_MASK);
        if (reg_hit) begin
            tgt_o = MMD_TGT_REG;
        end else if (ram_hit) begin
            tgt_o = MMD_TGT_RAM;
        end else if (boot_hit) begin
            tgt_o = MMD_TGT_BOOT;
        end else if (nv_hit) begin
            tgt_o = MMD_TGT_NV;
        end else if (ext_mode_i) begin
            tgt_o = MMD_TGT_EXT;
        end else begin
            tgt_o = MMD_TGT_NONE;
        end
    end

endmodule // mmd_addr_decode
`default_nettype wire

// file: hw/mmd_mode_latch.sv
`timescale 1ns/10ps
`default_nettype none
`include "mmd_params.svh"

module mmd_mode_latch (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mode_pin_a_i,
    input wire logic mode_pin_b_i,
    output logic load_o,
    output logic special_o,
    output logic sel_a_o
);
    logic [1:0] meta_reg;
    logic [1:0] sync_reg;
    logic done_reg;

    // ************************************
    // Pin synchroniser, runs through reset
    // ************************************
    always_ff @(posedge clk_i) begin
        meta_reg <= {mode_pin_b_i, mode_pin_a_i};
        sync_reg <= meta_reg;
    end

    // One capture at the first edge after reset release
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b1;
        end
    end

    assign load_o = ~done_reg;
    assign special_o = ~sync_reg[1];
    assign sel_a_o = sync_reg[0];

endmodule // mmd_mode_latch
`default_nettype wire

// file: hw/mmd_params.svh
`ifndef MMD_PARAMS_SVH
`define MMD_PARAMS_SVH

// Register word indices; byte address is four times the index
`define MMD_IDX_PORT_B 14'h1004
`define MMD_IDX_PORT_F 14'h1005
`define MMD_IDX_PORT_C 14'h1006
`define MMD_IDX_DIR_C 14'h1007
`define MMD_IDX_PRIO 14'h103c
`define MMD_IDX_MAP 14'h103d
`define MMD_IDX_OPT 14'h103f

// Priority/mode register fields
`define MMD_PRIO_BOOT 7
`define MMD_PRIO_SPECIAL_MODE_BIT 6
`define MMD_PRIO_MDA 5
`define MMD_PRIO_IRV 4
`define MMD_PSEL_RST 4'h5

// Mapping register
`define MMD_MAP_RST 8'h01
`define MMD_WIN_CYC 7'd64

// Option word: reset values, writable bits, bits that read as one
`define MMD_OPT_RST_FULL 8'hff
`define MMD_OPT_RST_RED 8'h00
`define MMD_OPT_WMASK_FULL 8'hf5
`define MMD_OPT_WMASK_RED 8'h04
`define MMD_OPT_ONES_FULL 8'h0a
`define MMD_OPT_ONES_RED 8'h00
`define MMD_OPT_NV_EN 0

// Address map
`define MMD_PAGE4K_MASK 16'hf000
`define MMD_RAM_MASK 16'hfc00
`define MMD_REG_PAD 12'h000
`define MMD_RAM_PAD 10'h000
`define MMD_REG_SPAN 12'h060
`define MMD_NV_LOW 12'he00
`define MMD_NV_MASK 16'hfe00
`define MMD_NV_FIX_BASE 16'hfe00
`define MMD_BOOT_BASE 16'hbf00
`define MMD_BOOT_MASK 16'hff00

`endif

// file: hw/mmd_pkg.sv
package mmd_pkg;

    // Resource that answers a CPU access
    typedef enum logic [2:0] {
        MMD_TGT_NONE,
        MMD_TGT_RAM,
        MMD_TGT_REG,
        MMD_TGT_BOOT,
        MMD_TGT_NV,
        MMD_TGT_EXT
    } mmd_tgt_t;

endpackage

// file: hw/mmd_top.sv
// Design decision made here: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
`include "mmd_params.svh"

module mmd_top import mmd_pkg::*; #(
    parameter bit FULL_VARIANT = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mode_pin_a_i,
    input wire logic mode_pin_b_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic cpu_valid_i,
    input wire logic cpu_we_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    output logic sel_ram_o,
    output logic sel_reg_o,
    output logic sel_boot_o,
    output logic sel_nv_o,
    output logic sel_ext_o,
    output logic [7:0] ext_rdata_o,
    output logic [7:0] port_b_o,
    output logic [7:0] port_f_o,
    output logic [7:0] port_c_o,
    output logic [7:0] port_c_oe_o,
    input wire logic [7:0] port_c_i,
    output logic special_mode_o,
    output logic expanded_bus_o
);

    // ************************************
    // Declarations
    // ************************************
    logic strap_load;
    logic strap_special;
    logic strap_sel_a;

    logic boot_rom_en_reg;
    logic special_mode_bit_reg;
    logic mode_select_a_bit_reg;
    logic irv_reg;
    logic irv_written_reg;
    logic [3:0] psel_reg;

    logic [7:0] map_reg;
    logic map_written_reg;
    logic [6:0] win_cnt_reg;
    logic map_wr_ok;

    logic [7:0] opt_reg;
    logic [7:0] port_b_reg;
    logic [7:0] port_f_reg;
    logic [7:0] port_c_reg;
    logic [7:0] dir_c_reg;
    logic [7:0] pc_meta_reg;
    logic [7:0] pc_sync_reg;

    logic wb_ack_reg;
    logic [31:0] wb_dat_reg;
    logic wb_take;
    logic wb_wr;
    logic [13:0] wb_idx;
    logic [7:0] wb_byte;
    logic [7:0] rd_mux;

    logic [5:0] ram_page;
    logic [3:0] reg_page;
    logic nv_en;
    logic boot_en;
    mmd_tgt_t tgt;

    // ************************************
    // Mode pin capture
    // ************************************
    mmd_mode_latch u_mode_latch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_pin_a_i(mode_pin_a_i),
        .mode_pin_b_i(mode_pin_b_i),
        .load_o(strap_load),
        .special_o(strap_special),
        .sel_a_o(strap_sel_a)
    );

    // ************************************
    // Wishbone slave decode
    // ************************************
    // Request taken once, ack one cycle later
    assign wb_take = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
    assign wb_wr = wb_take & wb_we_i & wb_sel_i[0];
    assign wb_idx = wb_adr_i[15:2];
    assign wb_byte = wb_dat_i[7:0];

    // Word index match helper, used per register
    function automatic logic is_idx(input logic [13:0] idx, input logic [13:0] want);
        return idx == want;
    endfunction

    // Normal-mode window for the mapping register
    assign map_wr_ok = special_mode_bit_reg
                       | (~map_written_reg & (win_cnt_reg < `MMD_WIN_CYC));

    // ************************************
    // Mode and priority register
    // ************************************
    // Strap capture, then software writes per mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            boot_rom_en_reg <= 1'b0;
            special_mode_bit_reg <= 1'b0;
            mode_select_a_bit_reg <= 1'b0;
            irv_reg <= 1'b0;
            irv_written_reg <= 1'b0;
            psel_reg <= `MMD_PSEL_RST;
        end else if (strap_load) begin
            special_mode_bit_reg <= strap_special;
            mode_select_a_bit_reg <= strap_sel_a;
            boot_rom_en_reg <= strap_special & ~strap_sel_a;
            irv_reg <= strap_special;
        end else if (wb_wr && is_idx(wb_idx, `MMD_IDX_PRIO)) begin
            psel_reg <= wb_byte[3:0];
            if (special_mode_bit_reg) begin
                boot_rom_en_reg <= wb_byte[`MMD_PRIO_BOOT];
                // Special bit may be cleared but never set again
                special_mode_bit_reg <= wb_byte[`MMD_PRIO_SPECIAL_MODE_BIT];
                mode_select_a_bit_reg <= wb_byte[`MMD_PRIO_MDA];
                irv_reg <= wb_byte[`MMD_PRIO_IRV];
            end else if (!irv_written_reg) begin
                irv_reg <= wb_byte[`MMD_PRIO_IRV];
                irv_written_reg <= 1'b1;
            end
        end
    end

    // ************************************
    // Mapping register and write window
    // ************************************
    // Cycle count since reset, saturating
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_cnt_reg <= 7'h00;
        end else if (win_cnt_reg < `MMD_WIN_CYC) begin
            win_cnt_reg <= win_cnt_reg + 7'h01;
        end
    end

    // Map value, one write in normal modes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            map_reg <= `MMD_MAP_RST;
            map_written_reg <= 1'b0;
        end else if (wb_wr && is_idx(wb_idx, `MMD_IDX_MAP) && map_wr_ok) begin
            map_reg <= wb_byte;
            map_written_reg <= ~special_mode_bit_reg;
        end
    end

    // ************************************
    // System option word
    // ************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opt_reg <= FULL_VARIANT ? `MMD_OPT_RST_FULL : `MMD_OPT_RST_RED;
        end else if (wb_wr && is_idx(wb_idx, `MMD_IDX_OPT)) begin
            if (FULL_VARIANT) begin
                opt_reg <= (wb_byte & `MMD_OPT_WMASK_FULL) | `MMD_OPT_ONES_FULL;
            end else begin
                opt_reg <= (wb_byte & `MMD_OPT_WMASK_RED) | `MMD_OPT_ONES_RED;
            end
        end
    end

    // ************************************
    // General-purpose port registers
    // ************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_b_reg <= 8'h00;
            port_f_reg <= 8'h00;
            port_c_reg <= 8'h00;
            dir_c_reg <= 8'h00;
        end else if (wb_wr) begin
            if (is_idx(wb_idx, `MMD_IDX_PORT_B)) begin
                port_b_reg <= wb_byte;
            end
            if (is_idx(wb_idx, `MMD_IDX_PORT_F)) begin
                port_f_reg <= wb_byte;
            end
            if (is_idx(wb_idx, `MMD_IDX_PORT_C)) begin
                port_c_reg <= wb_byte;
            end
            if (is_idx(wb_idx, `MMD_IDX_DIR_C)) begin
                dir_c_reg <= wb_byte;
            end
        end
    end

    // Port C pin synchroniser
    always_ff @(posedge clk_i) begin
        pc_meta_reg <= port_c_i;
        pc_sync_reg <= pc_meta_reg;
    end

    // ************************************
    // Register read mux
    // ************************************
    // Unmapped words read as zero
    always_comb begin
        rd_mux = 8'h00;
        if (is_idx(wb_idx, `MMD_IDX_PRIO)) begin
            rd_mux = {boot_rom_en_reg, special_mode_bit_reg,
                      mode_select_a_bit_reg, irv_reg, psel_reg};
        end else if (is_idx(wb_idx, `MMD_IDX_MAP)) begin
            rd_mux = map_reg;
        end else if (is_idx(wb_idx, `MMD_IDX_OPT)) begin
            rd_mux = opt_reg;
        end else if (is_idx(wb_idx, `MMD_IDX_PORT_B)) begin
            rd_mux = port_b_reg;
        end else if (is_idx(wb_idx, `MMD_IDX_PORT_F)) begin
            rd_mux = port_f_reg;
        end else if (is_idx(wb_idx, `MMD_IDX_PORT_C)) begin
            // Inputs show the pin, outputs the latch
            rd_mux = (pc_sync_reg & ~dir_c_reg) | (port_c_reg & dir_c_reg);
        end else if (is_idx(wb_idx, `MMD_IDX_DIR_C)) begin
            rd_mux = dir_c_reg;
        end
    end

    // Ack and read data, one cycle after take
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_reg <= 1'b0;
            wb_dat_reg <= 32'h00000000;
        end else begin
            wb_ack_reg <= wb_take;
            if (wb_take) begin
                wb_dat_reg <= {24'h000000, rd_mux};
            end
        end
    end

    assign wb_ack_o = wb_ack_reg;
    assign wb_dat_o = wb_dat_reg;

    // ************************************
    // Address map
    // ************************************
    // Variant-specific page fields
    always_comb begin
        if (FULL_VARIANT) begin
            ram_page = {map_reg[7:4], 2'b00};
            reg_page = map_reg[3:0];
        end else begin
            ram_page = map_reg[7:2];
            reg_page = {2'b00, map_reg[1:0]};
        end
    end

    assign nv_en = opt_reg[`MMD_OPT_NV_EN];
    assign boot_en = boot_rom_en_reg & special_mode_bit_reg
                     & ~mode_select_a_bit_reg;

    // Full 16-bit decode of each CPU access
    mmd_addr_decode #(
        .FULL_VARIANT(FULL_VARIANT)
    ) u_decode (
        .addr_i(cpu_addr_i),
        .ram_page_i(ram_page),
        .reg_page_i(reg_page),
        .nv_page_i(opt_reg[7:4]),
        .nv_en_i(nv_en),
        .fixed_nv_i(~mode_select_a_bit_reg),
        .boot_en_i(boot_en),
        .ext_mode_i(mode_select_a_bit_reg),
        .tgt_o(tgt)
    );

    // Registered resource selects
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_ram_o <= 1'b0;
            sel_reg_o <= 1'b0;
            sel_boot_o <= 1'b0;
            sel_nv_o <= 1'b0;
            sel_ext_o <= 1'b0;
        end else begin
            sel_ram_o <= cpu_valid_i && (tgt == MMD_TGT_RAM);
            sel_reg_o <= cpu_valid_i && (tgt == MMD_TGT_REG);
            sel_boot_o <= cpu_valid_i && (tgt == MMD_TGT_BOOT);
            sel_nv_o <= cpu_valid_i && (tgt == MMD_TGT_NV);
            sel_ext_o <= cpu_valid_i && (tgt == MMD_TGT_EXT);
        end
    end

    // ************************************
    // Port pins and external bus
    // ************************************
    // Expanded bus or general-purpose ports
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_b_o <= 8'h00;
            port_f_o <= 8'h00;
            port_c_o <= 8'h00;
            port_c_oe_o <= 8'h00;
        end else if (mode_select_a_bit_reg) begin
            port_b_o <= cpu_addr_i[15:8];
            port_f_o <= cpu_addr_i[7:0];
            port_c_o <= cpu_wdata_i;
            port_c_oe_o <= {8{cpu_valid_i && cpu_we_i && (tgt == MMD_TGT_EXT)}};
        end else begin
            port_b_o <= port_b_reg;
            port_f_o <= port_f_reg;
            port_c_o <= port_c_reg;
            port_c_oe_o <= dir_c_reg;
        end
    end

    // External read data and mode status
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_rdata_o <= 8'h00;
            special_mode_o <= 1'b0;
            expanded_bus_o <= 1'b0;
        end else begin
            ext_rdata_o <= pc_sync_reg;
            special_mode_o <= special_mode_bit_reg;
            expanded_bus_o <= mode_select_a_bit_reg;
        end
    end

endmodule // mmd_top
`default_nettype wire

// file: tb/mmd_ext_mem.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// External memory on the expanded bus
// ****************************************
module mmd_ext_mem (
    input wire logic clk_i,
    input wire logic [7:0] addr_lo_i,
    input wire logic [7:0] data_i,
    input wire logic [7:0] oe_i,
    output logic [7:0] pin_o
);
    logic [7:0] mem [256];

    // Cleared store so reads never return unknowns
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    end

    // Capture a byte while the device drives the data lines
    always @(posedge clk_i) begin
        if (&oe_i) mem[addr_lo_i] <= data_i;
    end

    // Wire level: device drive wins per bit, memory drives the rest
    assign pin_o = (oe_i & data_i) | (~oe_i & mem[addr_lo_i]);
endmodule // mmd_ext_mem

`default_nettype wire

// file: tb/mmd_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Decode and mode checker
// ****************************************
module mmd_chk import mmd_pkg::*; #(
    parameter bit FULL_VARIANT = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mode_pin_a_i,
    input wire logic mode_pin_b_i,
    input wire logic cpu_we_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    input wire logic sel_ram_o,
    input wire logic sel_reg_o,
    input wire logic sel_boot_o,
    input wire logic sel_nv_o,
    input wire logic sel_ext_o,
    input wire logic [7:0] port_b_o,
    input wire logic [7:0] port_f_o,
    input wire logic [7:0] port_c_o,
    input wire logic [7:0] port_c_oe_o,
    input wire logic special_mode_o,
    input wire logic expanded_bus_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Expanded mode, then an external write decoded
    sequence ext_wr_s;
        expanded_bus_o ##1 (sel_ext_o && $past(cpu_we_i));
    endsequence

    sel_single_a: assert property ($onehot0({sel_ram_o, sel_reg_o, sel_boot_o, sel_nv_o, sel_ext_o}))
        else $error("more than one target selected");
    boot_special_a: assert property (sel_boot_o |-> special_mode_o && !expanded_bus_o
        && ($past(cpu_addr_i) & 16'hff00) == 16'hbf00) else $error("boot rom selected wrongly");
    nv_top_a: assert property (sel_nv_o |-> ($past(cpu_addr_i) & 16'h0e00) == 16'h0e00)
        else $error("array selected outside its window");
    nv_fixed_a: assert property (sel_nv_o && !expanded_bus_o
        |-> ($past(cpu_addr_i) & 16'hfe00) == 16'hfe00) else $error("array not at top page");
    no_ext_single_a: assert property (!expanded_bus_o |-> !sel_ext_o)
        else $error("external access in single chip");
    addr_out_a: assert property (expanded_bus_o && $past(expanded_bus_o)
        |-> {port_b_o, port_f_o} == $past(cpu_addr_i)) else $error("address not on ports");
    data_out_a: assert property (ext_wr_s |-> port_c_oe_o == 8'hff
        && port_c_o == $past(cpu_wdata_i)) else $error("write data not driven");
    // Pins land in the mode bits at the capture edge, outputs one edge later
    mode_capture_a: assert property ($fell(rst_i) |-> ##2 (special_mode_o
        == !mode_pin_b_i && expanded_bus_o == mode_pin_a_i))
        else $error("mode bits not latched from pins");
    // Normal modes move only through reset; special modes may rewrite the bits
    mode_hold_a: assert property (!$past(special_mode_o) && ($changed(special_mode_o)
        || $changed(expanded_bus_o)) |-> $past(rst_i, 3))
        else $error("mode changed outside reset");
endmodule // mmd_chk

bind mmd_top mmd_chk #(.FULL_VARIANT(FULL_VARIANT)) u_chk (.clk_i, .rst_i, .mode_pin_a_i,
    .mode_pin_b_i, .cpu_we_i, .cpu_addr_i, .cpu_wdata_i, .sel_ram_o, .sel_reg_o, .sel_boot_o,
    .sel_nv_o, .sel_ext_o, .port_b_o, .port_f_o, .port_c_o, .port_c_oe_o, .special_mode_o,
    .expanded_bus_o);

`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
    typedef struct {logic b; logic a; logic [7:0] p; logic [15:0] ad; logic [4:0] s;} mmd_row_t;
    logic clk_i = 1'b0;
    logic rst_i, mode_pin_a_i, mode_pin_b_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic r_ram, r_reg, r_boot, r_nv, r_ext;
    logic cpu_valid_i, cpu_we_i, sel_ram_o, sel_reg_o, sel_boot_o, sel_nv_o, sel_ext_o;
    logic special_mode_o, expanded_bus_o;
    logic [15:0] wb_adr_i, cpu_addr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q, red_dat_o;
    logic [7:0] cpu_wdata_i, ext_rdata_o, port_b_o, port_f_o, port_c_o, port_c_oe_o, port_c_i;
    int fails, tests_run;
    // Pins b, a, priority reset value, cpu address, targets {ram,reg,boot,nv,ext}
    mmd_row_t rows[17] = '{
        '{1, 0, 8'h05, 16'h0010, 5'h10}, '{1, 0, 8'h05, 16'h03ff, 5'h10},
        '{1, 0, 8'h05, 16'h0400, 5'h00}, '{1, 0, 8'h05, 16'h105f, 5'h08},
        '{1, 0, 8'h05, 16'h1060, 5'h00}, '{1, 0, 8'h05, 16'hbf00, 5'h00},
        '{1, 0, 8'h05, 16'hfe00, 5'h02}, '{1, 1, 8'h25, 16'h8000, 5'h01},
        '{1, 1, 8'h25, 16'hfdff, 5'h01}, '{1, 1, 8'h25, 16'hfe00, 5'h02},
        '{1, 1, 8'h25, 16'hbf00, 5'h01}, '{0, 0, 8'hd5, 16'hbf00, 5'h04},
        '{0, 0, 8'hd5, 16'hbfff, 5'h04}, '{0, 0, 8'hd5, 16'hc000, 5'h00},
        '{0, 0, 8'hd5, 16'hfe00, 5'h02}, '{0, 1, 8'h75, 16'hbf00, 5'h01},
        '{0, 1, 8'h75, 16'h1000, 5'h08}};

    mmd_top #(.FULL_VARIANT(1'b1)) dut (.clk_i, .rst_i, .mode_pin_a_i, .mode_pin_b_i, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cpu_valid_i,
        .cpu_we_i, .cpu_addr_i, .cpu_wdata_i, .sel_ram_o, .sel_reg_o, .sel_boot_o, .sel_nv_o,
        .sel_ext_o, .ext_rdata_o, .port_b_o, .port_f_o, .port_c_o, .port_c_oe_o, .port_c_i,
        .special_mode_o, .expanded_bus_o);
    mmd_ext_mem u_mem (.clk_i, .addr_lo_i(port_f_o), .data_i(port_c_o), .oe_i(port_c_oe_o),
        .pin_o(port_c_i));
    // Reduced variant on the same buses; its selects are checked by hand
    mmd_top #(.FULL_VARIANT(1'b0)) dut_red (.clk_i, .rst_i, .mode_pin_a_i, .mode_pin_b_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o(red_dat_o),
        .wb_ack_o(), .cpu_valid_i, .cpu_we_i, .cpu_addr_i, .cpu_wdata_i, .sel_ram_o(r_ram),
        .sel_reg_o(r_reg), .sel_boot_o(r_boot), .sel_nv_o(r_nv), .sel_ext_o(r_ext),
        .ext_rdata_o(), .port_b_o(), .port_f_o(), .port_c_o(), .port_c_oe_o(), .port_c_i,
        .special_mode_o(), .expanded_bus_o());

    // Bus clock, 50 ns period
    always #25 clk_i = ~clk_i;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Classic single cycle, held until ack is sampled high
    task automatic wb(input logic we, input logic [15:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= 4'h1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1) begin
            fails++;
            results();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    // CPU access held two edges; selects then show its decode
    task automatic cpu(input logic [15:0] a, input logic we, input logic [7:0] d);
        @(posedge clk_i);
        cpu_valid_i <= 1'b1;
        cpu_addr_i <= a;
        cpu_we_i <= we;
        cpu_wdata_i <= d;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic tgt(input logic [15:0] a, input logic [4:0] e);
        cpu(a, 1'b0, 8'h00);
        chk("target", {27'h0, sel_ram_o, sel_reg_o, sel_boot_o, sel_nv_o, sel_ext_o}, e);
    endtask

    // Reduced variant decode of the access still held by the last tgt call
    task automatic red(input logic [4:0] e);
        chk("reduced target", {27'h0, r_ram, r_reg, r_boot, r_nv, r_ext}, e);
    endtask

    // Reset with the straps held steady throughout
    task automatic boot_mode(input logic b, input logic a);
        @(posedge clk_i);
        rst_i <= 1'b1;
        mode_pin_b_i <= b;
        mode_pin_a_i <= a;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_i = 1'b1;
        {mode_pin_a_i, mode_pin_b_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b01000;
        {cpu_valid_i, cpu_we_i, wb_adr_i, cpu_addr_i, wb_sel_i} = '0;
        {wb_dat_i, cpu_wdata_i} = '0;
        fails = 0;
        tests_run = 0;
        for (int i = 0; i < 17; i++) begin
            if (i == 0 || {rows[i].b, rows[i].a} != {rows[i - 1].b, rows[i - 1].a}) begin
                boot_mode(rows[i].b, rows[i].a);
                wb(1'b0, 16'h40f0, 8'h00);
                chk("mode_priority_ctl", q, {24'h0, rows[i].p});
            end
            tgt(rows[i].ad, rows[i].s);
        end
        // Special test mode: map rewritable, overlap and array window
        wb(1'b1, 16'h40f4, 8'h22);
        wb(1'b1, 16'h40f4, 8'h11);
        wb(1'b0, 16'h40f4, 8'h00);
        chk("map special", q, 32'h11);
        tgt(16'h1000, 5'h08);
        tgt(16'h1060, 5'h10);
        tgt(16'h0010, 5'h01);
        wb(1'b1, 16'h40fc, 8'h35);
        wb(1'b0, 16'h40fc, 8'h00);
        chk("option", q, 32'h3f);
        tgt(16'h3e00, 5'h02);
        tgt(16'hfe00, 5'h01);
        wb(1'b1, 16'h40fc, 8'h34);
        tgt(16'h3e00, 5'h01);
        // Expanded: write then read external memory
        boot_mode(1'b1, 1'b1);
        cpu(16'h8012, 1'b1, 8'ha5);
        chk("ext bus", {port_b_o, port_f_o, port_c_o, port_c_oe_o}, 32'h8012a5ff);
        cpu(16'h8012, 1'b0, 8'h00);
        repeat (4) @(posedge clk_i);
        chk("ext read", {24'h0, ext_rdata_o}, 32'ha5);
        // Single chip: one map write, port registers, unmapped word
        boot_mode(1'b1, 1'b0);
        wb(1'b1, 16'h40f4, 8'h27);
        wb(1'b1, 16'h40f4, 8'h00);
        wb(1'b0, 16'h40f4, 8'h00);
        chk("map once", q, 32'h27);
        chk("map once reduced", red_dat_o, 32'h27);
        tgt(16'h2000, 5'h10);
        red(5'h00);
        tgt(16'h0010, 5'h00);
        tgt(16'h2400, 5'h00);
        red(5'h10);
        tgt(16'h3000, 5'h00);
        red(5'h08);
        tgt(16'h7000, 5'h08);
        red(5'h00);
        wb(1'b1, 16'h4010, 8'h5a);
        wb(1'b1, 16'h401c, 8'h0f);
        repeat (2) @(posedge clk_i);
        chk("ports", {16'h0, port_b_o, port_c_oe_o}, 32'h5a0f);
        wb(1'b0, 16'h4400, 8'h00);
        chk("unmapped", q, 32'h0);
        // Map write after the 64-cycle window is dropped
        boot_mode(1'b1, 1'b0);
        repeat (70) @(posedge clk_i);
        wb(1'b1, 16'h40f4, 8'h21);
        wb(1'b0, 16'h40f4, 8'h00);
        chk("map late", q, 32'h01);
        results();
    end
endmodule // tb

`default_nettype wire
